// >>> design/tone_sounder_pkg.sv
// Shared constants and types of the tone sounder and shutdown control.
package tone_sounder_pkg;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_HZ       = 50_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int MS_CYC       = CLK_HZ / MS_PER_S;
  localparam int DEBOUNCE_MS  = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * MS_CYC;

  // ************************************************
  // Tone command fields and codes
  // ************************************************
  localparam logic [7:0] TONE_CMD_RST   = 8'h00;
  localparam int         CFG_ENABLE_BIT = 7;
  localparam logic [3:0] FREQ_STATIC    = 4'h0;
  localparam logic [3:0] FREQ_STATIC_HI = 4'h1;
  localparam logic [3:0] FREQ_A6        = 4'hc;
  localparam logic [3:0] FREQ_C7        = 4'hd;
  localparam logic [3:0] FREQ_D7        = 4'he;
  localparam logic [3:0] FREQ_E7        = 4'hf;
  localparam int         HZ_A6          = 1760;
  localparam int         HZ_C7          = 2093;
  localparam int         DHZ_D7         = 23493;
  localparam int         DHZ_SCALE      = 10;
  localparam int         HZ_E7          = 2637;
  localparam int         HZ_OTHER       = 1000;
  localparam logic [2:0] DUR_CONT       = 3'h0;
  localparam logic [2:0] DUR_LONGEST    = 3'h7;
  localparam logic [13:0] DUR1_MS       = 14'd15625;
  localparam logic [13:0] DUR2_MS       = 14'd3125;
  localparam logic [13:0] DUR3_MS       = 14'd625;
  localparam logic [13:0] DUR4_MS       = 14'd125;
  localparam logic [13:0] DUR5_MS       = 14'd250;
  localparam logic [13:0] DUR6_MS       = 14'd500;
  localparam logic [13:0] DUR7_MS       = 14'd1000;

  // ************************************************
  // Matrix
  // ************************************************
  localparam int MAT_N = 8;
  localparam int KEYS  = MAT_N * MAT_N;

  // Frequency codes 0000 and 0001 hold the output static at bit 0's level.
  typedef struct packed {
    logic [2:0] dur;
    logic [3:0] freq;
    logic       buffer;
  } tone_cmd_type;

  typedef enum logic [2:0] {
    SND_IDLE = 3'b001,
    SND_HOST = 3'b010,
    SND_AUTO = 3'b100
  } snd_state_type;

endpackage

// >>> design/tone_sounder_shutdown_ctrl.sv
// Tone sounder, shutdown control and static key monitor of a key peripheral.
`timescale 1ns/1ps
module tone_sounder_shutdown_ctrl
#(
  parameter int HZ_CLOCK     = tone_sounder_pkg::CLK_HZ,
  parameter int MS_CYCLES    = tone_sounder_pkg::MS_CYC,
  parameter int DEBOUNCE_CYC = tone_sounder_pkg::DEBOUNCE_CYC
)
(
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          tone_wr,
  input  wire tone_sounder_pkg::tone_cmd_type tone_wdata,
  output logic                               tone_wr_ack_q,
  output logic                               tone_wr_nack_q,
  output tone_sounder_pkg::tone_cmd_type     tone_rdata_q,
  input  wire logic                          cfg_wr,
  input  wire logic [7:0]                    cfg_wdata,
  output logic                               enable_q,
  input  wire logic                          alert_pin,
  input  wire logic                          alert_irq_en,
  input  wire logic                          alert_sound_en,
  input  wire tone_sounder_pkg::tone_cmd_type alert_cmd,
  input  wire logic                          click_en,
  input  wire tone_sounder_pkg::tone_cmd_type click_cmd,
  input  wire logic                          int_clear,
  input  wire logic                          int_gpo_mode,
  input  wire logic                          int_gpo_level,
  output logic                               alert_status_q,
  output logic                               int_req_q,
  output logic                               int_pin_out_q,
  output logic                               int_pin_oe_q,
  input  wire logic                          gpo_wr,
  input  wire logic [5:0]                    gpo_wdata,
  output logic [5:0]                         gpo_out_q,
  output logic [5:0]                         gpo_oe_q,
  input  wire logic [63:0]                   key_sense,
  output logic [63:0]                        key_state_q,
  output logic                               key_fifo_clear_q,
  output logic [7:0]                         matrix_row_oe_q,
  output logic [7:0]                         matrix_col_oe_q,
  output logic                               tone_out_q
);
  import tone_sounder_pkg::*;

  // ************************************************
  // Shutdown control
  // ************************************************
  logic cfg_en_bit;
  logic wake;
  logic sleep;
  assign cfg_en_bit = cfg_wdata[CFG_ENABLE_BIT];
  assign wake  = cfg_wr && cfg_en_bit && !enable_q;
  assign sleep = cfg_wr && !cfg_en_bit && enable_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      enable_q         <= 1'b0;
      key_fifo_clear_q <= 1'b0;
      matrix_row_oe_q  <= 8'h00;
      matrix_col_oe_q  <= 8'h00;
    end
    else
    begin
      if (cfg_wr)
        enable_q <= cfg_en_bit;
      key_fifo_clear_q <= wake;
      // Lines float in shutdown so no current flows into pressed keys.
      matrix_row_oe_q <= (cfg_wr ? cfg_en_bit : enable_q) ? 8'hff : 8'h00;
      matrix_col_oe_q <= (cfg_wr ? cfg_en_bit : enable_q) ? 8'hff : 8'h00;
    end
  end

  // ************************************************
  // Alert, interrupt and general-purpose outputs
  // ************************************************
  logic alert_meta_q;
  logic alert_sync_q;
  logic alert_rise;
  assign alert_rise = alert_sync_q && !alert_status_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      alert_meta_q   <= 1'b0;
      alert_sync_q   <= 1'b0;
      alert_status_q <= 1'b0;
      int_req_q      <= 1'b0;
      int_pin_out_q  <= 1'b0;
      int_pin_oe_q   <= 1'b0;
      gpo_out_q      <= 6'h3f;
      gpo_oe_q       <= 6'h00;
    end
    else
    begin
      alert_meta_q   <= alert_pin;
      alert_sync_q   <= alert_meta_q;
      alert_status_q <= alert_sync_q;
      if (alert_rise && alert_irq_en)
        int_req_q <= 1'b1;
      else if (int_clear)
        int_req_q <= 1'b0;
      int_pin_out_q <= 1'b0;
      int_pin_oe_q  <= int_gpo_mode ? !int_gpo_level : int_req_q;
      if (gpo_wr)
      begin
        gpo_out_q <= gpo_wdata;
        gpo_oe_q  <= ~gpo_wdata;
      end
    end
  end

  // ************************************************
  // Static key monitor with ghost suppression
  // ************************************************
  logic [63:0] key_meta_q;
  logic [63:0] key_sync_q;
  logic [63:0] key_raw;
  logic [63:0] key_clean;
  logic [63:0] key_samp_q;
  logic [31:0] deb_cnt_q;
  logic        click_q;
  assign key_raw = enable_q ? key_sync_q : 64'h0;

  for (genvar k = 0; k < KEYS; k++)
  begin : g_ghost
    always_comb
    begin
      automatic logic ghost    = 1'b0;
      automatic logic row_mate = 1'b0;
      automatic logic col_mate = 1'b0;
      automatic logic diag     = 1'b0;
      for (int r = 0; r < MAT_N; r++)
        for (int c = 0; c < MAT_N; c++)
          if (r != k / MAT_N && c != k % MAT_N)
          begin
            row_mate = key_raw[(k / MAT_N) * MAT_N + c];
            col_mate = key_raw[r * MAT_N + k % MAT_N];
            diag     = key_raw[r * MAT_N + c];
            // Any three corners make the fourth look pressed.
            ghost |= (row_mate & col_mate) | (row_mate & diag)
                   | (col_mate & diag);
          end
      key_clean[k] = key_raw[k] && !ghost;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      key_meta_q  <= 64'h0;
      key_sync_q  <= 64'h0;
      key_samp_q  <= 64'h0;
      key_state_q <= 64'h0;
      deb_cnt_q   <= 32'h0;
      click_q     <= 1'b0;
    end
    else
    begin
      key_meta_q <= key_sense;
      key_sync_q <= key_meta_q;
      click_q    <= 1'b0;
      // Counter sleeps while nothing is pressed: it holds at zero, and only the key synchronizer clocks then.
      if (wake || key_clean == 64'h0)
      begin
        key_samp_q  <= 64'h0;
        key_state_q <= 64'h0;
        deb_cnt_q   <= 32'h0;
      end
      else if (key_clean != key_samp_q)
      begin
        key_samp_q <= key_clean;
        deb_cnt_q  <= 32'h0;
      end
      else if (deb_cnt_q == 32'(DEBOUNCE_CYC - 1))
      begin
        key_state_q <= key_samp_q;
        click_q     <= |(key_samp_q & ~key_state_q);
      end
      else
        deb_cnt_q <= deb_cnt_q + 32'h1;
    end
  end

  // ************************************************
  // Sounder
  // ************************************************
  snd_state_type state_q;
  tone_cmd_type  cur_q;
  tone_cmd_type  queue_q;
  tone_cmd_type  aq_q;
  logic          queue_v_q;
  logic          aq_v_q;
  logic          expired_q;
  logic          restart_q;
  logic [15:0]   half_cnt_q;
  logic [31:0]   ms_cnt_q;
  logic [13:0]   left_q;
  logic          auto_evt;
  tone_cmd_type  auto_cmd;
  logic          host_ok;
  logic          half_end;
  logic          finish;

  function automatic logic [15:0] half_of(input logic [3:0] f);
    unique case (f)
      FREQ_A6: half_of = 16'(HZ_CLOCK / (2 * HZ_A6));
      FREQ_C7: half_of = 16'(HZ_CLOCK / (2 * HZ_C7));
      FREQ_D7: half_of = 16'(HZ_CLOCK * DHZ_SCALE / (2 * DHZ_D7));
      FREQ_E7: half_of = 16'(HZ_CLOCK / (2 * HZ_E7));
      default: half_of = 16'(HZ_CLOCK / (2 * HZ_OTHER));
    endcase
  endfunction

  function automatic logic [13:0] ms_of(input logic [2:0] d);
    unique case (d)
      3'h1:    ms_of = DUR1_MS;
      3'h2:    ms_of = DUR2_MS;
      3'h3:    ms_of = DUR3_MS;
      3'h4:    ms_of = DUR4_MS;
      3'h5:    ms_of = DUR5_MS;
      3'h6:    ms_of = DUR6_MS;
      default: ms_of = DUR7_MS;
    endcase
  endfunction

  function automatic logic is_static(input logic [3:0] f);
    is_static = f[3:1] == 3'h0;
  endfunction

  function automatic logic first_level(input tone_cmd_type c);
    first_level = is_static(c.freq) ? c.freq[0] : 1'b1;
  endfunction

  always_comb
  begin
    auto_cmd = (alert_rise && alert_sound_en) ? alert_cmd : click_cmd;
    if (auto_cmd.dur == DUR_CONT)
      auto_cmd.dur = DUR_LONGEST;
    auto_evt = (alert_rise && alert_sound_en) || (click_q && click_en);
  end
  // Automatic sounds own the sounder until the last queued one is done.
  assign host_ok  = enable_q && state_q != SND_AUTO && !aq_v_q;
  assign half_end = half_cnt_q == half_of(cur_q.freq) - 16'h1;
  // The old expiry must not end a command that has only just been loaded.
  assign finish   = expired_q && !restart_q && (is_static(cur_q.freq)
                                  || (half_end && tone_out_q));

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q        <= SND_IDLE;
      cur_q          <= TONE_CMD_RST;
      queue_q        <= TONE_CMD_RST;
      aq_q           <= TONE_CMD_RST;
      queue_v_q      <= 1'b0;
      aq_v_q         <= 1'b0;
      tone_out_q     <= 1'b0;
      tone_wr_ack_q  <= 1'b0;
      tone_wr_nack_q <= 1'b0;
      restart_q      <= 1'b0;
    end
    else
    begin
      tone_wr_ack_q  <= tone_wr && host_ok && !auto_evt;
      tone_wr_nack_q <= tone_wr && !(host_ok && !auto_evt);
      restart_q      <= 1'b0;
      if (sleep || wake)
      begin
        queue_v_q <= 1'b0;
        aq_v_q    <= 1'b0;
        state_q   <= SND_IDLE;
      end
      else if (!enable_q)
        ; // Output held at its last level through shutdown.
      else if (auto_evt && state_q == SND_AUTO)
      begin
        aq_q   <= auto_cmd;
        aq_v_q <= 1'b1;
      end
      else if (auto_evt)
      begin
        cur_q      <= auto_cmd;
        state_q    <= SND_AUTO;
        queue_v_q  <= 1'b0;
        restart_q  <= 1'b1;
        tone_out_q <= first_level(auto_cmd);
      end
      else if (tone_wr && host_ok)
      begin
        if (!tone_wdata.buffer)
        begin
          cur_q      <= tone_wdata;
          state_q    <= SND_HOST;
          queue_v_q  <= 1'b0;
          restart_q  <= 1'b1;
          tone_out_q <= first_level(tone_wdata);
        end
        else if (state_q == SND_HOST)
        begin
          queue_q   <= tone_wdata;
          queue_v_q <= 1'b1;
        end
        else if (tone_wdata != 8'h01)
        begin
          cur_q      <= tone_wdata;
          state_q    <= SND_HOST;
          restart_q  <= 1'b1;
          tone_out_q <= first_level(tone_wdata);
        end
      end
      else if (state_q != SND_IDLE && finish)
      begin
        if (aq_v_q)
        begin
          cur_q      <= aq_q;
          aq_v_q     <= 1'b0;
          restart_q  <= 1'b1;
          tone_out_q <= first_level(aq_q);
        end
        else if (queue_v_q)
        begin
          cur_q      <= queue_q;
          state_q    <= SND_HOST;
          queue_v_q  <= 1'b0;
          restart_q  <= 1'b1;
          tone_out_q <= first_level(queue_q);
        end
        else
        begin
          state_q    <= SND_IDLE;
          tone_out_q <= is_static(cur_q.freq) ? !cur_q.freq[0]
                                              : 1'b0;
        end
      end
      else if (state_q != SND_IDLE && !is_static(cur_q.freq) && half_end)
        tone_out_q <= !tone_out_q;
    end
  end

  // Duration timer; restarts whenever a new command becomes current.
  always_ff @(posedge clock)
  begin
    if (sys_rst || restart_q || state_q == SND_IDLE || !enable_q)
    begin
      half_cnt_q <= 16'h0;
      ms_cnt_q   <= 32'h0;
      left_q     <= ms_of(cur_q.dur);
      expired_q  <= 1'b0;
    end
    else
    begin
      half_cnt_q <= half_end ? 16'h0 : half_cnt_q + 16'h1;
      if (cur_q.dur != DUR_CONT && !expired_q)
      begin
        if (ms_cnt_q == 32'(MS_CYCLES - 1))
        begin
          ms_cnt_q  <= 32'h0;
          left_q    <= left_q - 14'h1;
          expired_q <= left_q == 14'h1;
        end
        else
          ms_cnt_q <= ms_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tone_rdata_q <= TONE_CMD_RST;
    else if (state_q == SND_IDLE)
      tone_rdata_q <= TONE_CMD_RST;
    else
      tone_rdata_q <= {cur_q[7:1], queue_v_q | aq_v_q};
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_auto_busy;
    tone_wr && state_q == SND_AUTO;
  endsequence

  a_shut_lines_off: assert property (sleep |=> ##1 matrix_row_oe_q == 8'h00
    && matrix_col_oe_q == 8'h00) else $error("lines not off");
  a_auto_write_nack: assert property (s_auto_busy |=> tone_wr_nack_q
    && !tone_wr_ack_q) else $error("write taken in auto");
  a_auto_preempt: assert property (auto_evt && enable_q && !sleep && !wake
    && state_q == SND_HOST |=> state_q == SND_AUTO && !queue_v_q)
    else $error("auto did not preempt");
  a_shut_output_hold: assert property (!enable_q && !cfg_wr |=>
    $stable(tone_out_q)) else $error("output moved in shutdown");
  a_wake_clear: assert property (wake |=> key_fifo_clear_q && !queue_v_q
    && !aq_v_q) else $error("wake did not clear");
  a_rewrite_keep: assert property (cfg_wr && cfg_en_bit && enable_q |=>
    !key_fifo_clear_q) else $error("rewrite cleared queues");
  a_ghost_hidden: assert property (&{key_raw[0], key_raw[1], key_raw[8]}
    |-> !(key_clean[0] | key_clean[1] | key_clean[8]
    | key_clean[9])) else $error("ghost reported");
  a_debounce_idle: assert property (key_clean == 64'h0 |=> deb_cnt_q == 32'h0
    && key_state_q == 64'h0) else $error("debounce ran idle");
  a_alert_irq: assert property (alert_rise && alert_irq_en |=> int_req_q
    ##1 int_pin_oe_q || int_gpo_mode) else $error("alert lost");
  a_gpo_follow: assert property (gpo_wr |=> gpo_out_q == $past(gpo_wdata)
    && gpo_oe_q == ~gpo_out_q) else $error("gpo not updated");
  a_tone_idle_low: assert property (state_q != SND_IDLE && finish && enable_q
    && !auto_evt && !tone_wr && !cfg_wr && !aq_v_q && !queue_v_q
    && !is_static(cur_q.freq) |=> state_q == SND_IDLE && !tone_out_q)
    else $error("tone did not idle low");

endmodule

// >>> tb/host_model.sv
// Host model driving the sounder, configuration and output ports.
`timescale 1ns/1ps
module host_model
(
  input  wire logic                 clock,
  input  wire logic                 ack,
  input  wire logic                 nack,
  output tone_sounder_pkg::tone_cmd_type tone_wdata,
  output logic                      tone_wr,
  output logic                      cfg_wr,
  output logic [7:0]                cfg_wdata,
  output logic                      gpo_wr,
  output logic [5:0]                gpo_wdata
);
  import tone_sounder_pkg::*;

  initial
  begin
    tone_wr = 1'b0;
    tone_wdata = '0;
    cfg_wr = 1'b0;
    cfg_wdata = 8'h00;
    gpo_wr = 1'b0;
    gpo_wdata = 6'h00;
  end

  // ****************************************
  // Transfers, each a one-cycle strobe
  // ****************************************
  // Released data is inverted so a stale value never looks valid.
  // A defined shutdown level needs a static command first.
  task automatic write_tone(input tone_cmd_type c, output logic [1:0] r);
    int n;
    tone_wdata = c;
    tone_wr = 1'b1;
    @(posedge clock);
    #1;
    tone_wr = 1'b0;
    tone_wdata = ~c;
    r = {ack, nack};
    for (n = 0; n < 2 && r == 2'b00; n++)
    begin
      @(posedge clock);
      #1;
      r = {ack, nack};
    end
  endtask

  task automatic write_cfg(input logic [7:0] d);
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clock);
    #1;
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask

  task automatic write_gpo(input logic [5:0] d);
    gpo_wdata = d;
    gpo_wr = 1'b1;
    @(posedge clock);
    #1;
    gpo_wr = 1'b0;
    gpo_wdata = ~d;
  endtask
endmodule

// >>> tb/tb_tone_sounder_shutdown_ctrl.sv
// Self-checking testbench of the tone sounder and shutdown control.
`timescale 1ns/1ps
module tb_tone_sounder_shutdown_ctrl;
  import tone_sounder_pkg::*;
  // Shortened clock and millisecond counts keep the run brief.
  localparam int HZ  = 35200;
  localparam int MSC = 2;
  localparam int DBC = 8;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic tone_wr, cfg_wr, gpo_wr, ack, nack, en, alert, irq_en, snd_en;
  logic [7:0] cfg_wdata, row_oe, col_oe;
  logic [5:0] gpo_wdata, gpo_out;
  logic [63:0] keys, key_state;
  logic kclr, st, irq, tone;
  logic ck_en, iclr, gmode, glvl, ipo, ipoe;
  logic [5:0] goe;
  tone_cmd_type ccmd;
  logic [1:0] resp;
  logic seen;
  tone_cmd_type wdata, rdata, acmd;
  int fails = 0;
  int checks_done = 0;
  int i, n, d;
  int dms[8];
  logic [3:0] fc[4];
  int dhz[4];

  always #10 clock = ~clock;

  tone_sounder_shutdown_ctrl #(.HZ_CLOCK(HZ), .MS_CYCLES(MSC),
    .DEBOUNCE_CYC(DBC)) dut (.clock(clock), .sys_rst(sys_rst),
    .tone_wr(tone_wr), .tone_wdata(wdata), .tone_wr_ack_q(ack),
    .tone_wr_nack_q(nack), .tone_rdata_q(rdata), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .enable_q(en), .alert_pin(alert),
    .alert_irq_en(irq_en), .alert_sound_en(snd_en), .alert_cmd(acmd),
    .click_en(ck_en), .click_cmd(ccmd), .int_clear(iclr),
    .int_gpo_mode(gmode), .int_gpo_level(glvl), .alert_status_q(st),
    .int_req_q(irq), .int_pin_out_q(ipo), .int_pin_oe_q(ipoe),
    .gpo_wr(gpo_wr), .gpo_wdata(gpo_wdata), .gpo_out_q(gpo_out),
    .gpo_oe_q(goe),
    .key_sense(keys), .key_state_q(key_state), .key_fifo_clear_q(kclr),
    .matrix_row_oe_q(row_oe), .matrix_col_oe_q(col_oe), .tone_out_q(tone));

  host_model host (.clock(clock), .ack(ack), .nack(nack),
    .tone_wdata(wdata), .tone_wr(tone_wr), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .gpo_wr(gpo_wr), .gpo_wdata(gpo_wdata));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic tone_cmd_type mk(input logic [2:0] du,
                                      input logic [3:0] f, input logic b);
    return '{dur: du, freq: f, buffer: b};
  endfunction

  task automatic step(input int k);
    repeat (k)
    begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("[ERR] %0t count %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded waits; a used-up bound ends the run as a mismatch.
  task automatic wait_idle(input int bound, output int k);
    // The read value turns busy only a cycle after the write is answered.
    step(1);
    k = 1;
    while (rdata !== '0 && k < bound)
    begin
      step(1);
      k++;
    end
    if (k >= bound)
    begin
      fails++;
      $display("[ERR] %0t sounder busy %h exp %h", $time, rdata, 8'h00);
      finish_test;
    end
  endtask

  task automatic wait_tone(input logic v, output int k);
    k = 0;
    while (tone !== v && k < 100)
    begin
      step(1);
      k++;
    end
    if (k >= 100)
    begin
      fails++;
      $display("[ERR] %0t tone stuck %h exp %h", $time, tone, v);
      finish_test;
    end
  endtask

  task automatic pulse_seen(output logic s);
    s = kclr;
    step(1);
    s = s | kclr;
    step(1);
    s = s | kclr;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {alert, irq_en, snd_en} = 3'b000;
    {ck_en, iclr, gmode, glvl} = 4'h0;
    ccmd = '0;
    keys = '0;
    acmd = '0;
    dms = '{0, DUR1_MS, DUR2_MS, DUR3_MS, DUR4_MS, DUR5_MS, DUR6_MS, DUR7_MS};
    fc = '{FREQ_A6, FREQ_C7, FREQ_D7, FREQ_E7};
    dhz = '{HZ_A6 * DHZ_SCALE, HZ_C7 * DHZ_SCALE, DHZ_D7, HZ_E7 * DHZ_SCALE};
    repeat (10) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    check_val({en, row_oe, col_oe, rdata, gpo_out}, 6'h3f);
    check_val({goe, ipo, ipoe}, 8'h00);
    host.write_tone(mk(3'h4, FREQ_A6, 1'b0), resp);
    check_val(resp, 2'b01);
    host.write_cfg(8'h80);
    pulse_seen(seen);
    check_val({seen, en, row_oe, col_oe}, 18'h3ffff);
    host.write_cfg(8'h80);
    pulse_seen(seen);
    check_val(seen, 1'b0);
    $display("test enable done");

    keys = 64'h3;
    step(DBC + 12);
    check_val(key_state, 64'h3);
    keys = 64'h103;
    step(DBC + 12);
    check_val(key_state, 64'h0);
    keys = '0;
    step(6);
    check_val(key_state, 64'h0);
    $display("test keys done");

    for (i = 0; i < 4; i++)
    begin
      host.write_tone(mk(3'h4, fc[i], 1'b0), resp);
      check_val(resp, 2'b10);
      wait_tone(1'b0, n);
      wait_tone(1'b1, n);
      wait_tone(1'b0, n);
      d = (HZ * DHZ_SCALE) / (2 * dhz[i]);
      check_cnt(n, d, d);
      wait_idle(400, n);
      check_val(tone, 1'b0);
    end
    $display("test frequencies done");

    for (i = 1; i < 8; i++)
    begin
      host.write_tone(mk(i[2:0], FREQ_A6, 1'b0), resp);
      d = dms[i] * MSC;
      wait_idle(d + 60, n);
      check_cnt(n, d - 3, d + 24);
    end
    $display("test durations done");

    acmd = mk(DUR_CONT, FREQ_E7, 1'b0);
    snd_en = 1'b1;
    host.write_tone(mk(DUR_CONT, FREQ_A6, 1'b0), resp);
    step(3000);
    check_val(rdata.freq, FREQ_A6);
    alert = 1'b1;
    step(6);
    check_val(rdata.freq, FREQ_E7);
    host.write_tone(mk(3'h4, FREQ_A6, 1'b0), resp);
    check_val({resp, rdata.freq}, {2'b01, FREQ_E7});
    d = DUR7_MS * MSC;
    wait_idle(d + 60, n);
    check_cnt(n, d - 20, d + 20);
    host.write_tone(mk(3'h4, FREQ_A6, 1'b0), resp);
    check_val(resp, 2'b10);
    wait_idle(400, n);
    $display("test alert done");

    alert = 1'b0;
    acmd = mk(3'h4, FREQ_C7, 1'b1);
    step(4);
    alert = 1'b1;
    step(10);
    alert = 1'b0;
    step(4);
    alert = 1'b1;
    step(4);
    check_val(rdata.buffer, 1'b1);
    host.write_tone(mk(3'h4, FREQ_A6, 1'b0), resp);
    check_val(resp, 2'b01);
    d = 2 * DUR4_MS * MSC;
    wait_idle(d + 80, n);
    check_cnt(n, d - 60, d + 40);
    $display("test alert queue done");

    ccmd = mk(DUR_CONT, FREQ_C7, 1'b0);
    ck_en = 1'b1;
    keys = 64'h3;
    step(DBC + 12);
    check_val({rdata.dur, rdata.freq}, {DUR_LONGEST, FREQ_C7});
    host.write_tone(mk(3'h4, FREQ_A6, 1'b0), resp);
    check_val(resp, 2'b01);
    keys = '0;
    d = DUR7_MS * MSC;
    wait_idle(d + 60, n);
    check_cnt(n, d - 40, d + 20);
    ck_en = 1'b0;
    $display("test key click done");

    {alert, snd_en} = 2'b00;
    step(6);
    host.write_tone(mk(DUR_CONT, FREQ_STATIC_HI, 1'b0), resp);
    step(3);
    check_val(tone, 1'b1);
    host.write_cfg(8'h00);
    step(2);
    check_val({en, row_oe, col_oe}, 17'h0);
    host.write_tone(mk(3'h4, FREQ_A6, 1'b0), resp);
    step(20);
    check_val({resp, tone}, 3'b011);
    irq_en = 1'b1;
    alert = 1'b1;
    step(6);
    check_val({st, irq}, 2'b11);
    host.write_gpo(6'h15);
    step(2);
    check_val({gpo_out, goe}, {6'h15, 6'h2a});
    check_val({ipo, ipoe}, 2'b01);
    {gmode, glvl} = 2'b11;
    step(2);
    check_val(ipoe, 1'b0);
    glvl = 1'b0;
    step(2);
    check_val(ipoe, 1'b1);
    {gmode, iclr} = 2'b01;
    step(1);
    iclr = 1'b0;
    step(2);
    check_val({irq, ipoe}, 2'b00);
    host.write_cfg(8'h80);
    pulse_seen(seen);
    check_val({seen, en}, 2'b11);
    $display("test shutdown done");
    finish_test;
  end
endmodule
